// *** rtl/wfc_pkg.sv ***
// wfc_pkg: shared constants and types of the wake-frame filter configuration bank
// assumes: 7-bit register addresses, 8-bit register data, one clock domain
package wfc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int WFC_ADDR_W = 7;                  // register address width
	localparam int WFC_DATA_W = 8;                  // register data width
	localparam int WFC_REG_COUNT = 11;              // registers held in the bank
	localparam logic [6:0] WFC_ADDR_CFG_CTRL = 7'h20;        // control word with the valid flag
	localparam logic [6:0] WFC_ADDR_ID_MID = 7'h24;          // wake_frame_id_mid
	localparam logic [6:0] WFC_ADDR_ID_LOW_MID = 7'h25;      // wake_frame_id_low_mid
	localparam logic [6:0] WFC_ADDR_ID_LOW_FLAGS = 7'h26;    // wake_frame_id_low_flags
	localparam logic [6:0] WFC_ADDR_MASK_HIGH = 7'h27;       // wake_frame_mask_high
	localparam logic [6:0] WFC_ADDR_MASK_MID = 7'h28;        // wake_frame_mask_mid
	localparam logic [6:0] WFC_ADDR_MASK_LOW_MID = 7'h29;    // wake_frame_mask_low_mid
	localparam logic [6:0] WFC_ADDR_MASK_LOW = 7'h2a;        // wake_frame_mask_low
	localparam logic [6:0] WFC_ADDR_LENGTH = 7'h2b;          // wake_frame_length
	localparam logic [6:0] WFC_ADDR_PAYLOAD7 = 7'h2c;        // wake_frame_payload_byte7
	localparam logic [6:0] WFC_ADDR_PAYLOAD6 = 7'h2d;        // wake_frame_payload_byte6
	localparam logic [6:0] WFC_ADDR_PAYLOAD5 = 7'h2e;        // wake_frame_payload_byte5

	// ----------------------------------------------------------------
	// bank slot indices (slot = address - first bank address)
	// ----------------------------------------------------------------
	localparam int WFC_IDX_ID_MID = 0;
	localparam int WFC_IDX_ID_LOW_MID = 1;
	localparam int WFC_IDX_ID_LOW_FLAGS = 2;
	localparam int WFC_IDX_MASK_HIGH = 3;
	localparam int WFC_IDX_MASK_MID = 4;
	localparam int WFC_IDX_MASK_LOW_MID = 5;
	localparam int WFC_IDX_MASK_LOW = 6;
	localparam int WFC_IDX_LENGTH = 7;
	localparam int WFC_IDX_PAYLOAD7 = 8;
	localparam int WFC_IDX_PAYLOAD6 = 9;
	localparam int WFC_IDX_PAYLOAD5 = 10;

	// ----------------------------------------------------------------
	// field layout and writable masks
	// ----------------------------------------------------------------
	localparam int WFC_IDE_POS = 0;                 // extension bit position
	localparam int WFC_RTR_POS = 1;                 // remote-request bit position
	localparam int WFC_ID_LOW_LSB = 2;              // ident_bits_4_0 low end
	localparam int WFC_ID_LOW_MSB = 6;              // ident_bits_4_0 high end
	localparam int WFC_CFG_VALID_POS = 0;           // config_valid_flag position
	localparam logic [7:0] WFC_WMASK_FULL = 8'hff;  // all bits writable
	localparam logic [7:0] WFC_WMASK_ID_LOW = 8'h7f;   // bit 7 reserved
	localparam logic [7:0] WFC_WMASK_MASK_LOW = 8'h7c; // bits 7, 1, 0 reserved
	localparam logic [7:0] WFC_WMASK_LENGTH = 8'h0f;   // bits 7..4 reserved
	localparam logic [WFC_REG_COUNT-1:0][7:0] WFC_REG_WMASK = {
		WFC_WMASK_FULL, WFC_WMASK_FULL, WFC_WMASK_FULL, WFC_WMASK_LENGTH,
		WFC_WMASK_MASK_LOW, WFC_WMASK_FULL, WFC_WMASK_FULL, WFC_WMASK_FULL,
		WFC_WMASK_ID_LOW, WFC_WMASK_FULL, WFC_WMASK_FULL};

	// ----------------------------------------------------------------
	// reset values and length limits
	// ----------------------------------------------------------------
	localparam logic [7:0] WFC_RESET_BYTE = 8'h00;  // every bank register clears to this
	localparam logic [3:0] WFC_LEN_MAX = 4'h8;      // longest payload in bytes

	// state of one bank register
	typedef struct packed {
		logic [7:0] value;                          // stored byte
	} wfc_reg_state_type;

	// state of the bank top
	typedef struct packed {
		logic [7:0] rdData;                         // read data, valid one cycle after the strobe
		logic configValid;                          // config_valid_flag
		logic [3:0] payloadBytes;                   // decoded payload length
	} wfc_state_type;

endpackage

// *** rtl/wfc_cfg_reg.sv ***
// wfc_cfg_reg: one 8-bit configuration register of the bank with a writable-bit mask
// assumes: write strobe and data from the same clock domain, one-cycle strobes
`timescale 1ns/1ns
module wfc_cfg_reg import wfc_pkg::*; #(
	parameter logic [6:0] REG_ADDR = 7'h00,         // address that selects this register
	parameter logic [7:0] WR_MASK = 8'hff           // writable bits, the rest read zero
) (
	input wire logic ref_clk,                       // logic clock
	input wire logic reset_n,                       // power-on reset, active low
	input wire logic softReset,                     // synchronous soft reset pulse
	input wire logic wrEn,                          // write strobe
	input wire logic [6:0] wrAddr,                  // write address
	input wire logic [7:0] wrData,                  // write data
	output logic [7:0] value,                       // stored byte
	output logic changed                            // this write alters the stored byte
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	wfc_reg_state_type st_r;                        // registered state
	wfc_reg_state_type st_nxt;                      // next state
	logic hit;                                      // write addresses this register

	assign hit = wrEn && (wrAddr == REG_ADDR);
	assign changed = hit && ((wrData & WR_MASK) != st_r.value);
	assign value = st_r.value;

	// next value: soft reset clears, a write stores only writable bits
	always_comb begin
		st_nxt = st_r;
		if (softReset) begin
			st_nxt.value = WFC_RESET_BYTE;
		end else if (hit) begin
			st_nxt.value = wrData & WR_MASK;
		end
	end

	// state register; restart is not a reset here, so contents survive it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // wfc_cfg_reg

// *** rtl/wfc_bank.sv ***
// wfc_bank: wake-frame filter configuration bank with its register port and matcher outputs
// assumes: register master and matcher on ref_clk (50 MHz); softReset, restartEntry and
// wakeDetected are one-cycle pulses from logic on the same clock
`timescale 1ns/1ns
module wfc_bank import wfc_pkg::*; (
	input wire logic ref_clk,                       // logic clock, 50 MHz
	input wire logic reset_n,                       // power-on reset, asynchronous, active low
	input wire logic softReset,                     // soft reset pulse
	input wire logic restartEntry,                  // pulse on entering restart
	input wire logic wakeDetected,                  // pulse when a wake-up has been taken
	input wire logic [6:0] regAddr,                 // register address
	input wire logic [7:0] regWrData,               // register write data
	input wire logic regWrite,                      // write strobe
	input wire logic regRead,                       // read strobe
	output logic [7:0] regRdData,                   // read data, one cycle after the read
	output logic configValid,                       // selective wake configuration valid
	output logic [20:0] identBits,                  // expected identifier bits 20..0
	output logic remoteRequest,                     // expected frame is remote request
	output logic extendedIdent,                     // expected identifier is 29 bits
	output logic [28:0] cmpMask,                    // compare mask bits 28..0 (28..21 from 0x27)
	output logic [3:0] lengthCode,                  // stored length code
	output logic [3:0] payloadBytes,                // decoded payload length, 0..8
	output logic [7:0] payloadByte7,                // expected payload byte 7
	output logic [7:0] payloadByte6,                // expected payload byte 6
	output logic [7:0] payloadByte5                 // expected payload byte 5
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	wfc_state_type st_r;                            // registered state
	wfc_state_type st_nxt;                          // next state
	logic [7:0] regVal [WFC_REG_COUNT];             // stored bank bytes
	logic [WFC_REG_COUNT-1:0] regChg;               // per-register changing write
	logic bankChange;                               // any bank register altered by this write
	logic inBank;                                   // address falls inside the bank
	logic [6:0] slotOffs;                           // address minus first bank address
	logic [3:0] slotIdx;                            // bank slot of the address
	logic cfgHit;                                   // write addresses the control word

	// ----------------------------------------------------------------
	// bank registers
	// ----------------------------------------------------------------
	// one register per address; reserved bits are cut by the writable mask so they
	// always read zero, and no restart input reaches them so contents survive it
	genvar g;
	generate
		for (g = 0; g < WFC_REG_COUNT; g++) begin : gen_reg
			wfc_cfg_reg #(
				.REG_ADDR(7'(WFC_ADDR_ID_MID + g)),
				.WR_MASK(WFC_REG_WMASK[g])
			) u_reg (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.softReset(softReset),          // clears to zero
				.wrEn(regWrite),                // takes the write in the same edge
				.wrAddr(regAddr),
				.wrData(regWrData),
				.value(regVal[g]),              // reserved bits held at zero
				.changed(regChg[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// bank occupies 0x24..0x2e contiguously, so a slot is the address offset
	assign inBank = (regAddr >= WFC_ADDR_ID_MID) && (regAddr <= WFC_ADDR_PAYLOAD5);
	assign slotOffs = regAddr - WFC_ADDR_ID_MID;
	assign slotIdx = slotOffs[3:0];
	assign cfgHit = regWrite && (regAddr == WFC_ADDR_CFG_CTRL);
	assign bankChange = |regChg;

	// ----------------------------------------------------------------
	// length decode
	// ----------------------------------------------------------------
	// codes 0..7 are byte counts, anything above means a full eight bytes
	function automatic logic [3:0] decodeLength(input logic [3:0] code);
		logic [3:0] res;
		res = (code > 4'h7) ? WFC_LEN_MAX : code;
		return res;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// read data stands for one cycle only, zero otherwise
		st_nxt.rdData = WFC_RESET_BYTE;
		if (regRead) begin
			if (inBank) begin
				// every bank byte read back as stored
				st_nxt.rdData = regVal[slotIdx];
			end else if (regAddr == WFC_ADDR_CFG_CTRL) begin
				// control word: only the valid flag, the rest reads zero
				st_nxt.rdData = {7'h00, st_r.configValid};
			end
		end
		// decoded length follows the code in the same edge as the write
		if (softReset) begin
			st_nxt.payloadBytes = 4'h0;
		end else if (regWrite && (regAddr == WFC_ADDR_LENGTH)) begin
			st_nxt.payloadBytes = decodeLength(regWrData[3:0]);
		end
		// valid flag: software sets it; a changing write, wake-up, restart or reset clears it
		if (softReset) begin
			st_nxt.configValid = 1'b0;
		end else if (bankChange) begin
			st_nxt.configValid = 1'b0;
		end else if (cfgHit) begin
			// software set wins over a wake-up in the same cycle
			st_nxt.configValid = regWrData[WFC_CFG_VALID_POS];
		end else if (wakeDetected || restartEntry) begin
			st_nxt.configValid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs to software and to the frame matcher
	// ----------------------------------------------------------------
	assign regRdData = st_r.rdData;
	assign configValid = st_r.configValid;
	assign payloadBytes = st_r.payloadBytes;
	// identifier bits keep the 29-bit numbering; a standard identifier is
	// expected in bits 28..18, so bits 17..0 are then don't-care for the matcher
	assign identBits = {regVal[WFC_IDX_ID_MID], regVal[WFC_IDX_ID_LOW_MID],
		regVal[WFC_IDX_ID_LOW_FLAGS][WFC_ID_LOW_MSB:WFC_ID_LOW_LSB]};
	// 0 data frame, 1 remote request; software keeps this at 0 for wake-up
	assign remoteRequest = regVal[WFC_IDX_ID_LOW_FLAGS][WFC_RTR_POS];
	// 0 standard 11-bit, 1 extended 29-bit identifier
	assign extendedIdent = regVal[WFC_IDX_ID_LOW_FLAGS][WFC_IDE_POS];
	// a set mask bit means compare that identifier bit, a clear one ignores it
	assign cmpMask = {regVal[WFC_IDX_MASK_HIGH], regVal[WFC_IDX_MASK_MID],
		regVal[WFC_IDX_MASK_LOW_MID],
		regVal[WFC_IDX_MASK_LOW][WFC_ID_LOW_MSB:WFC_ID_LOW_LSB]};
	assign lengthCode = regVal[WFC_IDX_LENGTH][3:0];
	assign payloadByte7 = regVal[WFC_IDX_PAYLOAD7];
	assign payloadByte6 = regVal[WFC_IDX_PAYLOAD6];
	assign payloadByte5 = regVal[WFC_IDX_PAYLOAD5];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// identifier mid byte reads back in the following cycle
	a_id_mid_read: assert property (regRead && regAddr == WFC_ADDR_ID_MID
		|=> regRdData == $past(identBits[20:13]))
		else $error("identifier bits 20..13 read back wrong");

	// identifier low-mid byte written then visible on the outputs
	a_id_lowmid_write: assert property (regWrite && regAddr == WFC_ADDR_ID_LOW_MID && !softReset
		|=> identBits[12:5] == $past(regWrData))
		else $error("identifier bits 12..5 not stored");

	// flags byte: bit 7 always reads zero, flags land in the right places
	a_id_flags_layout: assert property (regWrite && regAddr == WFC_ADDR_ID_LOW_FLAGS && !softReset
		##1 regRead && regAddr == WFC_ADDR_ID_LOW_FLAGS
		|=> regRdData == ($past(regWrData, 2) & WFC_WMASK_ID_LOW)
			&& remoteRequest == regRdData[WFC_RTR_POS] && extendedIdent == regRdData[WFC_IDE_POS])
		else $error("identifier flags byte layout wrong");

	// low mask byte reserved bits read zero
	a_mask_low_rsvd: assert property (regRead && regAddr == WFC_ADDR_MASK_LOW
		|=> regRdData[7] == 1'b0 && regRdData[1:0] == 2'b00)
		else $error("mask low reserved bits not zero");

	// mask high byte drives compare mask bits 28..21
	a_mask_high_out: assert property (regWrite && regAddr == WFC_ADDR_MASK_HIGH && !softReset
		|=> cmpMask[28:21] == $past(regWrData))
		else $error("mask bits 28..21 not stored");

	// length register upper nibble reads zero
	a_len_rsvd: assert property (regRead && regAddr == WFC_ADDR_LENGTH
		|=> regRdData[7:4] == 4'h0)
		else $error("length reserved bits not zero");

	// decoded payload length always agrees with the stored code
	a_len_decode: assert property (payloadBytes == ((lengthCode > 4'h7) ? WFC_LEN_MAX : lengthCode))
		else $error("payload length decode wrong");

	// payload byte 7 updates on the edge after the write
	a_payload_write: assert property (regWrite && regAddr == WFC_ADDR_PAYLOAD7 && !softReset
		|=> payloadByte7 == $past(regWrData))
		else $error("payload byte 7 not stored");

	// soft reset clears identifier, compare mask, length code, payload bytes and the valid flag
	a_soft_reset_clr: assert property (softReset
		|=> identBits == '0 && cmpMask == '0 && lengthCode == 4'h0 && !configValid
			&& payloadByte7 == 8'h00 && payloadByte6 == 8'h00 && payloadByte5 == 8'h00)
		else $error("soft reset left bank contents");

	// restart without a write keeps identifier, mask, length code and payload byte 5 stable into the next cycle
	a_restart_keep: assert property (restartEntry && !regWrite && !softReset
		|=> $stable(identBits) && $stable(cmpMask) && $stable(lengthCode) && $stable(payloadByte5))
		else $error("restart altered bank contents");

	// a write that alters bank data drops the valid flag
	a_change_clears: assert property (regWrite && inBank && ((regWrData & WFC_REG_WMASK[slotIdx])
		!= regVal[slotIdx]) |=> !configValid)
		else $error("valid flag survived a configuration change");

	// a write of the same value leaves the flag alone
	a_same_keeps: assert property (configValid && regWrite && inBank && !softReset && !wakeDetected
		&& !restartEntry && ((regWrData & WFC_REG_WMASK[slotIdx]) == regVal[slotIdx])
		|=> configValid)
		else $error("valid flag dropped by an unchanged write");

	// identifier and compare mask outputs follow a written value for the whole time no write or reset intervenes
	a_outputs_hold: assert property (!regWrite && !softReset |=> $stable(identBits) && $stable(cmpMask))
		else $error("matcher outputs moved without a write");

	cover_flag_set: cover property (cfgHit && regWrData[WFC_CFG_VALID_POS] ##1 configValid);
	cover_flag_cleared: cover property (configValid ##1 regWrite && bankChange ##1 !configValid);
	cover_long_code: cover property (regWrite && regAddr == WFC_ADDR_LENGTH && regWrData[3:0] == 4'hf);
	cover_extended: cover property (extendedIdent && cmpMask != '0);

endmodule // wfc_bank

// *** test/wfc_bank_tb.sv ***
// testbench: self-checking bench for the wake-frame filter configuration bank
// assumes: wfc_pkg and wfc_bank compiled first; bench acts as the register master on ref_clk
`timescale 1ns/1ns
module testbench;

	// ----------------------------------------------------------------
	// compare macro, counters and stimulus signals
	// ----------------------------------------------------------------
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
	$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

	int miscompares = 0;                            // failed compares
	int checksDone = 0;                             // compares made
	int cycleCount = 0;                             // cycles run, for the hang guard
	localparam int CYCLE_LIMIT = 3000;              // far above the few hundred cycles used
	logic ref_clk = 1'b0;                           // 50 MHz clock
	logic reset_n = 1'b0;                           // power-on reset, active low
	logic softReset = 1'b0;                         // soft reset pulse
	logic restartEntry = 1'b0;                      // restart entry pulse
	logic wakeDetected = 1'b0;                      // wake taken pulse
	logic [6:0] regAddr = 7'h00;                    // register address
	logic [7:0] regWrData = 8'h00;                  // write data
	logic regWrite = 1'b0;                          // write strobe
	logic regRead = 1'b0;                           // read strobe
	logic [7:0] regRdData;                          // read data
	logic configValid;                              // valid flag
	logic [20:0] identBits;                         // identifier 20..0
	logic remoteRequest;                            // remote request bit
	logic extendedIdent;                            // extension bit
	logic [28:0] cmpMask;                           // compare mask
	logic [3:0] lengthCode;                         // stored length code
	logic [3:0] payloadBytes;                       // decoded length
	logic [7:0] payloadByte7;                       // payload byte 7
	logic [7:0] payloadByte6;                       // payload byte 6
	logic [7:0] payloadByte5;                       // payload byte 5
	logic [7:0] vals [11] = '{8'ha5, 8'h3c, 8'hfd, 8'h5a, 8'hc3, 8'h96, 8'hff, 8'hfa, 8'h11, 8'h22, 8'h33};
	logic [7:0] rdv;                                // last read value

	always #10 ref_clk = ~ref_clk;                 // 20 ns period

	wfc_bank uut (.ref_clk(ref_clk), .reset_n(reset_n), .softReset(softReset), .restartEntry(restartEntry),
		.wakeDetected(wakeDetected), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .configValid(configValid), .identBits(identBits),
		.remoteRequest(remoteRequest), .extendedIdent(extendedIdent), .cmpMask(cmpMask),
		.lengthCode(lengthCode), .payloadBytes(payloadBytes), .payloadByte7(payloadByte7),
		.payloadByte6(payloadByte6), .payloadByte5(payloadByte5));

	// ----------------------------------------------------------------
	// bus tasks and helpers
	// ----------------------------------------------------------------
	// writable bits of each bank address; reserved bits read back zero
	function automatic logic [7:0] wm(input logic [6:0] a);
		case (a)
			7'h26: wm = 8'h7f;
			7'h2a: wm = 8'h7c;
			7'h2b: wm = 8'h0f;
			default: wm = 8'hff;
		endcase
	endfunction

	// one-cycle write; outputs settled when the task returns
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		#1;
	endtask

	// one-cycle read; data taken in the cycle after the strobe
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		d = regRdData;
	endtask

	// read every bank register and compare with the table under the writable masks
	task automatic check_bank(input logic zero);
		for (int i = 0; i < 11; i++) begin
			rd(7'(7'h24 + i), rdv);
			`CHECK(rdv, zero ? 8'h00 : (vals[i] & wm(7'(7'h24 + i))))
		end
	endtask

	// verdict and end of run
	task automatic wrapUp();
		$display("checks done %0d, miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge ref_clk) begin
		cycleCount++;
		if (cycleCount >= CYCLE_LIMIT) begin
			miscompares++;
			wrapUp();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		check_bank(1'b1);
		rd(7'h7f, rdv);
		`CHECK(rdv, 8'h00)                           // unmapped read gives zero
		// fill the bank, then read back and inspect the matcher outputs
		for (int i = 0; i < 11; i++) wr(7'(7'h24 + i), vals[i]);
		check_bank(1'b0);
		`CHECK(identBits, {8'ha5, 8'h3c, 5'h1f})
		`CHECK({remoteRequest, extendedIdent}, 2'b01)
		`CHECK(cmpMask, {8'h5a, 8'hc3, 8'h96, 5'h1f})
		`CHECK({payloadByte7, payloadByte6, payloadByte5}, 24'h112233)
		@(posedge ref_clk) #1 `CHECK(regRdData, 8'h00) // read data stands one cycle only
		// flag survives an unchanged write, falls on a changing one
		wr(7'h20, 8'h01);
		`CHECK(configValid, 1'b1)
		rd(7'h20, rdv);
		`CHECK(rdv, 8'h01)                           // control word reads back the flag
		wr(7'h2c, 8'h11);
		`CHECK(configValid, 1'b1)
		wr(7'h2c, 8'h12);
		vals[8] = 8'h12;
		`CHECK({configValid, payloadByte7}, 9'h012)
		wr(7'h20, 8'h01);
		`CHECK(configValid, 1'b1)
		@(posedge ref_clk) wakeDetected <= 1'b1;
		@(posedge ref_clk) wakeDetected <= 1'b0;
		#1 `CHECK(configValid, 1'b0)                 // wake clears the flag
		// restart keeps the contents; an unmapped write changes nothing
		wr(7'h20, 8'h01);
		`CHECK(configValid, 1'b1)
		@(posedge ref_clk) restartEntry <= 1'b1;
		@(posedge ref_clk) restartEntry <= 1'b0;
		#1 `CHECK(configValid, 1'b0)                 // restart clears the flag
		wr(7'h23, 8'hff);
		check_bank(1'b0);
		// identifier length bit back to standard
		wr(7'h26, 8'h80);
		`CHECK({remoteRequest, extendedIdent, identBits[4:0]}, 7'h00)
		vals[2] = 8'h80;
		// write then read the flags byte with no gap between the strobes; remote bit kept at zero
		@(posedge ref_clk) begin
			regWrite <= 1'b1;
			regAddr <= 7'h26;
			regWrData <= 8'hf9;
		end
		@(posedge ref_clk) begin
			regWrite <= 1'b0;
			regRead <= 1'b1;
		end
		@(posedge ref_clk) regRead <= 1'b0;
		#1 `CHECK(regRdData, 8'h79)
		`CHECK({remoteRequest, extendedIdent, identBits[4:0]}, 7'h3e)
		// every length code, reserved upper bits written with the value 0xa
		for (int c = 0; c < 16; c++) begin
			wr(7'h2b, {4'ha, 4'(c)});
			`CHECK(payloadBytes, (c > 7) ? 4'h8 : 4'(c))
			`CHECK(lengthCode, 4'(c))
			rd(7'h2b, rdv);
			`CHECK(rdv, {4'h0, 4'(c)})
		end
		// soft reset clears everything
		@(posedge ref_clk) softReset <= 1'b1;
		@(posedge ref_clk) softReset <= 1'b0;
		#1 `CHECK({configValid, identBits, cmpMask, payloadBytes}, 55'h0)
		check_bank(1'b1);
		wrapUp();
	end

endmodule // testbench
